// ===== src/rsw_top.sv
`timescale 1ns/1ns
`include "rsw_cfg.svh"

module rsw_top #(
    parameter int                 PRESCALE    = `RSW_PRESCALE,
    parameter rsw_pkg::rsw_word_t INIT_COUNT  = `RSW_INIT_COUNT,
    parameter rsw_pkg::rsw_word_t INIT_ALARM  = `RSW_INIT_ALARM,
    parameter logic               POWER_UP_ON = `RSW_POWER_UP_ON
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               crystal_clock_input,
    input  wire logic               cfg_clk,
    input  wire logic               cfg_sel,
    input  wire logic               cfg_wr,
    input  wire rsw_pkg::rsw_addr_t cfg_addr,
    input  wire rsw_pkg::rsw_byte_t cfg_wdata,
    output rsw_pkg::rsw_byte_t      cfg_rdata,
    input  wire logic               standby_request_input,
    input  wire logic               wake_pin,
    output logic                    timer_match_flag,
    output logic                    wake_match_flag,
    output logic                    fabric_power_on
);
    import rsw_pkg::*;

    localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
    localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE - 1);
    localparam int SYNC_W = 2 + 1 + 1 + 4 + 8 + 1 + 1;   // Clocks, select, write, address, data, standby, wake

    // Pick one byte out of a 40-bit word; index above 4 reads zero
    function automatic rsw_byte_t word_byte(input rsw_word_t w, input logic [2:0] idx);
        rsw_byte_t b;
        b = 8'h00;
        if (idx <= 3'h4) begin
            b = w[idx*8 +: 8];
        end
        return b;
    endfunction

    // ---------------- Pin synchronisation ----------------
    logic [SYNC_W-1:0] pins_raw;       // All foreign-domain inputs
    logic [SYNC_W-1:0] pins_sync;      // After two flops
    logic              xtal_s;         // Crystal level, synchronised
    logic              bus_clk_s;      // Bus clock, synchronised
    logic              bus_sel_s;      // Select, synchronised
    logic              bus_wr_s;       // Write strobe, synchronised
    rsw_addr_t         bus_addr_s;     // Address, synchronised
    rsw_byte_t         bus_wdata_s;    // Write data, synchronised
    logic              stby_req_s;     // Standby request, synchronised
    logic              wake_pin_s;     // Wake pin, synchronised

    // Crystal and bus clock on top, standby and wake at the bottom
    assign pins_raw = {crystal_clock_input, cfg_clk, cfg_sel, cfg_wr, cfg_addr,
                       cfg_wdata, standby_request_input, wake_pin};

    // One synchroniser for every pin; bus master holds fields stable
    // across its clock edge, far longer than the two-flop latency
    rsw_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    assign xtal_s      = pins_sync[SYNC_W-1];
    assign bus_clk_s   = pins_sync[SYNC_W-2];
    assign bus_sel_s   = pins_sync[SYNC_W-3];
    assign bus_wr_s    = pins_sync[SYNC_W-4];
    assign bus_addr_s  = pins_sync[SYNC_W-5 -: 4];
    assign bus_wdata_s = pins_sync[SYNC_W-9 -: 8];
    assign stby_req_s  = pins_sync[1];
    assign wake_pin_s  = pins_sync[0];

    // ---------------- Edge detection ----------------
    logic xtal_d;          // Previous crystal level
    logic bus_clk_d;       // Previous bus clock level
    logic stby_req_d;      // Previous standby request level
    logic xtal_rise;       // Crystal rising edge
    logic bus_rise;        // Bus clock rising edge
    logic stby_rise;       // New standby request

    // Delay stage for edge detectors
    // Bus clock and standby idle low, so low reset values give no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            xtal_d     <= 1'b0;
            bus_clk_d  <= 1'b0;
            stby_req_d <= 1'b0;
        end else begin
            xtal_d     <= xtal_s;
            bus_clk_d  <= bus_clk_s;
            stby_req_d <= stby_req_s;
        end
    end

    assign xtal_rise = xtal_s & ~xtal_d;
    assign bus_rise  = bus_clk_s & ~bus_clk_d;
    assign stby_rise = stby_req_s & ~stby_req_d;

    // ---------------- Control register ----------------
    rsw_byte_t ctrl;            // Software-written control bits
    logic      reset_on_match;  // Clear counter after match
    logic      wake_on_match;   // Export match to supply monitor
    logic      xtal_cnt_mode;   // Crystal steered to the counter

    assign reset_on_match = ctrl[`RSW_CTRL_RESET_ON_MATCH];
    assign wake_on_match  = ctrl[`RSW_CTRL_WAKE_ON_MATCH];
    assign xtal_cnt_mode  = ctrl[`RSW_CTRL_XTAL_CNT_MODE];

    // ---------------- Prescaler ----------------
    logic [PW-1:0] prescale_cnt;   // Crystal edges in this period
    logic          count_tick;     // One counter advance

    // Crystal edges only count once the oscillator sources the counter
    assign count_tick = xtal_rise & xtal_cnt_mode & (prescale_cnt == PRESCALE_LAST);

    // Divide crystal edges by the prescale
    always_ff @(posedge clk) begin
        if (rst) begin
            prescale_cnt <= '0;
        end else if (!xtal_cnt_mode) begin
            prescale_cnt <= '0;
        end else if (xtal_rise) begin
            if (prescale_cnt == PRESCALE_LAST) begin
                prescale_cnt <= '0;
            end else begin
                prescale_cnt <= prescale_cnt + PW'(1);
            end
        end
    end

    // ---------------- Counter and compare ----------------
    rsw_word_t time_count;       // Live counter
    rsw_word_t alarm_compare;    // Active compare value
    rsw_word_t alarm_stage;      // Low bytes awaiting commit
    rsw_word_t next_time_count;  // Counter after this tick
    logic      match_now;        // Counter equals compare

    assign match_now = (time_count == alarm_compare);

    // Clear on match only when enabled, else wrap naturally
    assign next_time_count = (match_now && reset_on_match) ? '0
                                                           : time_count + 40'h1;

    // Counter advances on prescaled crystal ticks
    always_ff @(posedge clk) begin
        if (rst) begin
            time_count <= INIT_COUNT;
        end else if (count_tick) begin
            time_count <= next_time_count;
        end
    end

    // Match flags follow equality; both raised together
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_match_flag <= 1'b0;
            wake_match_flag  <= 1'b0;
        end else begin
            timer_match_flag <= match_now;
            wake_match_flag  <= match_now;
        end
    end

    // ---------------- Configuration bus decode ----------------
    logic      bus_write;     // Write taken this cycle
    logic      bus_read;      // Read taken this cycle
    logic      hit_count;     // Counter bytes addressed
    logic      hit_alarm;     // Compare bytes addressed
    logic      hit_ctrl;      // Control byte addressed
    logic      hit_status;    // Status byte addressed
    logic [2:0] count_idx;    // Byte index into counter
    logic [2:0] alarm_idx;    // Byte index into compare
    rsw_word_t count_snap;    // Counter frozen at low-byte read
    rsw_byte_t status;        // Block state for software
    rsw_byte_t next_rdata;    // Read data for this access

    assign bus_write  = bus_rise & bus_sel_s & bus_wr_s;
    assign bus_read   = bus_rise & bus_sel_s & ~bus_wr_s;
    assign hit_count  = (bus_addr_s <= `RSW_ADDR_COUNT4);
    assign hit_alarm  = (bus_addr_s >= `RSW_ADDR_ALARM0) && (bus_addr_s <= `RSW_ADDR_ALARM4);
    assign hit_ctrl   = (bus_addr_s == `RSW_ADDR_CTRL);
    assign hit_status = (bus_addr_s == `RSW_ADDR_STATUS);
    assign count_idx  = bus_addr_s[2:0];
    assign alarm_idx  = 3'(bus_addr_s - `RSW_ADDR_ALARM0);

    // Counting bit mirrors the crystal-steering control bit
    assign status = {5'h00,
                     count_tick | xtal_cnt_mode,
                     timer_match_flag,
                     fabric_power_on};

    // Low byte reads live; upper bytes come from the snapshot so
    // a multi-byte read is never torn by a carry between reads
    assign next_rdata = (hit_count && count_idx == 3'h0) ? word_byte(time_count, 3'h0) :
                        hit_count  ? word_byte(count_snap, count_idx) :
                        hit_alarm  ? word_byte(alarm_compare, alarm_idx) :
                        hit_ctrl   ? ctrl :
                        hit_status ? status :
                                     8'h00;

    // Read data register and counter snapshot
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_rdata  <= 8'h00;
            count_snap <= '0;
        end else if (bus_read) begin
            cfg_rdata <= next_rdata;
            if (hit_count && count_idx == 3'h0) begin
                count_snap <= time_count;
            end
        end
    end

    // Compare bytes stage up, the top byte commits all five so the
    // comparator never sees a half-written value
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_compare <= INIT_ALARM;
            alarm_stage   <= INIT_ALARM;
        end else if (bus_write && hit_alarm) begin
            if (bus_addr_s == `RSW_ADDR_ALARM4) begin
                alarm_compare <= {bus_wdata_s, alarm_stage[31:0]};
            end else begin
                alarm_stage[alarm_idx*8 +: 8] <= bus_wdata_s;
            end
        end
    end

    // Control register write; status and counter are read only
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= `RSW_CTRL_RESET;
        end else if (bus_write && hit_ctrl) begin
            ctrl <= bus_wdata_s;
        end
    end

    // ---------------- Regulator supply monitor ----------------
    rsw_pwr_state_t pwr_state;       // Fabric supply state
    rsw_pwr_state_t next_pwr_state;  // Supply state next cycle
    logic           wake_event;      // Any wake source
    logic           sleep_event;     // New standby request

    // Match wakes only while the control bit exports it to the monitor
    assign wake_event  = wake_pin_s | (wake_on_match & wake_match_flag);
    assign sleep_event = stby_rise;

    // Standby entry and exit; wake wins if both arrive together
    always_comb begin
        next_pwr_state = pwr_state;
        unique case (pwr_state)
            RSW_PWR_ON: begin
                if (sleep_event && !wake_event) begin
                    next_pwr_state = RSW_PWR_STANDBY;
                end
            end
            RSW_PWR_STANDBY: begin
                if (wake_event) begin
                    next_pwr_state = RSW_PWR_ON;
                end
            end
        endcase
    end

    // Supply state register; power-up state chosen by parameter
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_state <= POWER_UP_ON ? RSW_PWR_ON : RSW_PWR_STANDBY;
        end else begin
            pwr_state <= next_pwr_state;
        end
    end

    // Regulated output follows the state from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            fabric_power_on <= POWER_UP_ON;
        end else begin
            fabric_power_on <= (next_pwr_state == RSW_PWR_ON);
        end
    end
endmodule

// ===== src/rsw_cfg.svh
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH

// Configuration bus byte addresses
`define RSW_ADDR_COUNT0     4'h0
`define RSW_ADDR_COUNT4     4'h4
`define RSW_ADDR_ALARM0     4'h5
`define RSW_ADDR_ALARM4     4'h9
`define RSW_ADDR_CTRL       4'ha
`define RSW_ADDR_STATUS     4'hb

// Control register fields
`define RSW_CTRL_RESET_ON_MATCH 0
`define RSW_CTRL_WAKE_ON_MATCH  1
`define RSW_CTRL_XTAL_CNT_MODE  2
`define RSW_CTRL_RESET          8'h07

// Status register fields
`define RSW_STAT_FABRIC_ON      0
`define RSW_STAT_TIMER_MATCH    1
`define RSW_STAT_COUNTING       2

// Reset values and counting
`define RSW_INIT_COUNT      40'h00_0000_0000
`define RSW_INIT_ALARM      40'h00_0000_0032
`define RSW_PRESCALE        128
`define RSW_POWER_UP_ON     1'b1

`endif

// ===== src/rsw_pkg.sv
package rsw_pkg;

    // Counter and compare word
    typedef logic [39:0] rsw_word_t;

    // Configuration bus address and data
    typedef logic [3:0]  rsw_addr_t;
    typedef logic [7:0]  rsw_byte_t;

    // Fabric supply state
    typedef enum logic {
        RSW_PWR_ON,
        RSW_PWR_STANDBY
    } rsw_pwr_state_t;

endpackage

// ===== src/rsw_sync.sv
`timescale 1ns/1ns

// Two-flop synchroniser for a group of pin inputs
module rsw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;    // First stage, read only by second stage

    // Plain two-stage shift, cleared by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ===== bench/rsw_monitor.sv
`timescale 1ns/1ns

// Port-level checks on the standby wake counter
module rsw_monitor #(
    parameter logic POWER_UP_ON = 1'b1
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               cfg_clk,
    input wire rsw_pkg::rsw_byte_t cfg_rdata,
    input wire logic               standby_request_input,
    input wire logic               wake_pin,
    input wire logic               timer_match_flag,
    input wire logic               wake_match_flag,
    input wire logic               fabric_power_on
);
    import rsw_pkg::*;

    // Single domain, so one clock and reset for all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Both flags move together
    property p_flags_pair;
        timer_match_flag == wake_match_flag;
    endproperty
    a_flags_pair: assert property (p_flags_pair) else $error("match flags differ");

    // Outputs leave reset at their initial values
    property p_reset_vals;
        $fell(rst) |-> cfg_rdata == 8'h00 && !timer_match_flag && fabric_power_on == POWER_UP_ON;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");

    // Equality holds for a whole counter tick
    property p_flag_width;
        $rose(timer_match_flag) |=> timer_match_flag [*8];
    endproperty
    a_flag_width: assert property (p_flag_width) else $error("match flag too short");

    // Read data moves only after a bus clock rise
    property p_rdata_quiet;
        !cfg_clk [*7] |-> $stable(cfg_rdata);
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data moved without access");

    // No standby without a request
    property p_stby_cause;
        !standby_request_input [*8] |-> !$fell(fabric_power_on);
    endproperty
    a_stby_cause: assert property (p_stby_cause) else $error("supply fell unrequested");

    // A request with no wake source powers down
    property p_stby_enter;
        $rose(standby_request_input) ##0 (!wake_pin && !wake_match_flag) [*8] |-> !fabric_power_on;
    endproperty
    a_stby_enter: assert property (p_stby_enter) else $error("standby not entered");

    // Wake pin held restores the supply
    property p_wake_pin;
        wake_pin [*6] |-> fabric_power_on;
    endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("wake pin ignored");

    // Match flag in standby restores the supply
    property p_match_wakes;
        !fabric_power_on && wake_match_flag ##1 wake_match_flag |-> ##[0:2] fabric_power_on;
    endproperty
    a_match_wakes: assert property (p_match_wakes) else $error("match did not wake");
endmodule

// ===== bench/rsw_fabric_model.sv
`timescale 1ns/1ns

// Fabric-side master of the configuration bus
module rsw_fabric_model (
    input  wire logic               clk,
    output logic                    cfg_clk,
    output logic                    cfg_sel,
    output logic                    cfg_wr,
    output rsw_pkg::rsw_addr_t      cfg_addr,
    output rsw_pkg::rsw_byte_t      cfg_wdata,
    input  wire rsw_pkg::rsw_byte_t cfg_rdata
);
    import rsw_pkg::*;

    // Bus idle and deselected from time zero
    initial begin
        cfg_clk = 1'b0;
        cfg_sel = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 4'h0;
        cfg_wdata = 8'h00;
    end

    // One access; bus clock stands still between accesses, about 7 MHz inside
    task automatic access(input logic wr, input rsw_addr_t a, input rsw_byte_t d, output rsw_byte_t q);
        @(posedge clk);
        #1;
        cfg_sel = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_wdata = d;
        repeat (5) @(posedge clk);
        #1 cfg_clk = 1'b1;
        repeat (7) @(posedge clk);
        q = cfg_rdata;
        #1 cfg_clk = 1'b0;
        cfg_sel = 1'b0;
        // Released lines flip so stale values cannot pass
        cfg_wr = ~wr;
        cfg_addr = ~a;
        cfg_wdata = ~d;
        repeat (5) @(posedge clk);
        #1;
    endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
`include "rsw_cfg.svh"

module testbench;
    import rsw_pkg::*;
    localparam int PRE = 4;   // Short prescale keeps runs brief
    localparam int PER = 850; // Clk cycles per 17 ticks of 4 crystal periods

    logic      clk, rst, xtal, stby, wake, cfg_clk, cfg_sel, cfg_wr, tmf, wmf, pwr;
    rsw_addr_t cfg_addr;
    rsw_byte_t cfg_wdata, cfg_rdata, rd;
    int        error_cnt = 0;
    int        tests_run = 0;

    rsw_top #(.PRESCALE(PRE)) rsw_top_i (.clk(clk), .rst(rst), .crystal_clock_input(xtal), .cfg_clk(cfg_clk),
        .cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .standby_request_input(stby), .wake_pin(wake), .timer_match_flag(tmf), .wake_match_flag(wmf),
        .fabric_power_on(pwr));
    rsw_fabric_model rsw_fabric_model_i (.clk(clk), .cfg_clk(cfg_clk), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

    // Verdict and end of run
    task automatic results();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input rsw_word_t got, input rsw_word_t exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Bounded wait for flag or supply to reach a level
    task automatic wait_for(input logic on_pwr, input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim && (on_pwr ? pwr : tmf) !== lvl; n++) @(posedge clk) #1;
        if (n == lim) begin
            error_cnt++;
            $display("ERROR at %0t: wait ran out", $time);
            results();
        end
    endtask

    // Initial values, refused write, reserved read
    task automatic t_regs();
        rsw_addr_t a[5] = '{`RSW_ADDR_ALARM0, `RSW_ADDR_ALARM4, `RSW_ADDR_CTRL, 4'hc, `RSW_ADDR_STATUS};
        rsw_byte_t e[5] = '{8'h32, 8'h00, `RSW_CTRL_RESET, 8'h00, 8'h05};
        rsw_fabric_model_i.access(1'b1, `RSW_ADDR_STATUS, 8'h00, rd);
        for (int i = 0; i < 5; i++) begin
            rsw_fabric_model_i.access(1'b0, a[i], 8'h00, rd);
            chk(40'(rd), 40'(e[i]), "reset register");
        end
    endtask

    // New compare, paired flags, clear on match, match period
    task automatic t_match();
        longint t0;
        for (int i = 0; i < 5; i++) begin
            rsw_fabric_model_i.access(1'b1, rsw_addr_t'(`RSW_ADDR_ALARM0 + i), (i == 0) ? 8'h10 : 8'h00, rd);
        end
        rsw_fabric_model_i.access(1'b0, `RSW_ADDR_ALARM0, 8'h00, rd);
        chk(40'(rd), 40'h10, "compare readback");
        wait_for(1'b0, 1'b1, 2000);
        t0 = $time;
        chk(40'(wmf), 40'h1, "wake flag");
        wait_for(1'b0, 1'b0, 200);
        for (int i = 0; i < 5; i++) begin
            rsw_fabric_model_i.access(1'b0, rsw_addr_t'(i), 8'h00, rd);
            chk(40'(rd), 40'h0, "counter after match");
        end
        wait_for(1'b0, 1'b1, 2000);
        chk(40'(int'(($time - t0) / 8) > PER - 4 && int'(($time - t0) / 8) < PER + 4), 40'h1, "period");
    endtask

    // Standby, then wake by match and by pin
    task automatic t_standby();
        for (int k = 0; k < 2; k++) begin
            wait_for(1'b0, 1'b0, 2000);
            stby = 1'b1;
            repeat (8) @(posedge clk);
            #1 stby = 1'b0;
            chk(40'(pwr), 40'h0, "standby");
            if (k == 0) begin
                wait_for(1'b1, 1'b1, 1000);
                chk(40'(tmf), 40'h1, "match wake");
            end else begin
                wake = 1'b1;
                repeat (8) @(posedge clk);
                #1 chk(40'(pwr), 40'h1, "pin wake");
                wake = 1'b0;
            end
        end
    endtask

    // Halted counting, control readback, no clear on match
    task automatic t_ctrl();
        rsw_byte_t c0;
        rsw_fabric_model_i.access(1'b1, `RSW_ADDR_CTRL, 8'h03, rd);
        rsw_fabric_model_i.access(1'b0, `RSW_ADDR_COUNT0, 8'h00, c0);
        repeat (120) @(posedge clk);
        rsw_fabric_model_i.access(1'b0, `RSW_ADDR_COUNT0, 8'h00, rd);
        chk(40'(rd), 40'(c0), "counter halted");
        rsw_fabric_model_i.access(1'b0, `RSW_ADDR_STATUS, 8'h00, rd);
        chk(40'(rd), 40'h01, "status halted");
        rsw_fabric_model_i.access(1'b1, `RSW_ADDR_CTRL, 8'h06, rd);
        rsw_fabric_model_i.access(1'b0, `RSW_ADDR_CTRL, 8'h00, rd);
        chk(40'(rd), 40'h06, "control readback");
        wait_for(1'b0, 1'b1, 1000);
        wait_for(1'b0, 1'b0, 200);
        rsw_fabric_model_i.access(1'b0, `RSW_ADDR_COUNT0, 8'h00, rd);
        chk(40'(rd), 40'h11, "no clear on match");
    endtask

    // Core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Free crystal, 10 MHz, off the core edges
    initial begin
        xtal = 1'b0;
        #13;
        forever #50 xtal = ~xtal;
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        stby = 1'b0;
        wake = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        t_regs();
        t_match();
        t_standby();
        t_ctrl();
        results();
    end
endmodule

bind rsw_top rsw_monitor #(.POWER_UP_ON(POWER_UP_ON)) rsw_monitor_i (.clk(clk), .rst(rst), .cfg_clk(cfg_clk),
    .cfg_rdata(cfg_rdata), .standby_request_input(standby_request_input), .wake_pin(wake_pin),
    .timer_match_flag(timer_match_flag), .wake_match_flag(wake_match_flag), .fabric_power_on(fabric_power_on));
